// file: pbs_map.vh
// Constants for the packet buffer SRAM port.
// Included by bare name by the port and its serial loader.
`ifndef PBS_MAP_VH
`define PBS_MAP_VH
// Internal clock period, ns
`define PBS_CLK_NS          8
// Least half period of serial ROM clock, ns
`define PBS_ROM_HALF_NS     1000
// Serial ROM read opcode (start bit plus read)
`define PBS_ROM_OP_READ     3'h6
// Words fetched in the autoload
`define PBS_ROM_WORDS       8'h10
// Address widths of the small and large ROM
`define PBS_ROM_AW_SMALL    5'h06
`define PBS_ROM_AW_LARGE    5'h08
// SRAM access length in clock cycles
`define PBS_ACC_CYC         3'h3
// Requester indices
`define PBS_REQ_HOST        0
`define PBS_REQ_TX          1
`define PBS_REQ_RX          2
`endif

// file: pbs_rom_loader.v
// Serial ROM autoload engine: reads configuration words after reset.
// Assumes a microwire style ROM clocked from this block's divider.
`include "pbs_map.vh"
module pbs_rom_loader #(
	parameter HALF_CYC = (`PBS_ROM_HALF_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS
) (
	// Clock and reset
	input  wire        ref_clk_in,
	input  wire        reset_n_in,
	// Serial ROM pins
	input  wire        size_small_in,
	input  wire        rom_din_in,
	output reg         rom_sclk_out,
	output reg         rom_dout_out,
	output reg         rom_select_out,
	// Loaded words
	output reg  [15:0] cfg_word_out,
	output reg  [7:0]  cfg_index_out,
	output reg         cfg_valid_out,
	output reg         done_out
);
	localparam ST_CMD  = 2'h0;
	localparam ST_DATA = 2'h1;
	localparam ST_GAP  = 2'h2;
	localparam ST_DONE = 2'h3;
	reg [1:0]  state;
	reg [15:0] div;
	reg [4:0]  bitn;
	reg [15:0] shreg;
	reg [10:0] cmd;
	wire [4:0] aw = size_small_in ? `PBS_ROM_AW_SMALL : `PBS_ROM_AW_LARGE;
	wire       tick = (div == HALF_CYC[15:0] - 16'h0001);
	// Command bits: opcode then word address, MSB first
	always @* begin
		cmd = {`PBS_ROM_OP_READ, cfg_index_out << (5'h08 - aw)};
	end
	// Sequencer, one ROM bit per two half periods
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state          <= ST_CMD;
			div            <= 16'h0000;
			bitn           <= 5'h00;
			shreg          <= 16'h0000;
			rom_sclk_out   <= 1'b0;
			rom_dout_out   <= 1'b0;
			rom_select_out <= 1'b0;
			cfg_word_out   <= 16'h0000;
			cfg_index_out  <= 8'h00;
			cfg_valid_out  <= 1'b0;
			done_out       <= 1'b0;
		end else begin
			cfg_valid_out <= 1'b0;
			div <= tick ? 16'h0000 : div + 16'h0001;
			if (tick && state != ST_DONE) begin
				case (state)
				ST_CMD: begin
					rom_select_out <= 1'b1;
					if (!rom_sclk_out)
						rom_dout_out <= cmd[10 - bitn];
					else if (bitn == aw + 5'h02) begin
						bitn  <= 5'h00;
						state <= ST_DATA;
					end else
						bitn <= bitn + 5'h01;
					rom_sclk_out <= ~rom_sclk_out;
				end
				ST_DATA: begin
					rom_dout_out <= 1'b0;
					// Sample on rising clock edge
					if (!rom_sclk_out) begin
						shreg <= {shreg[14:0], rom_din_in};
						if (bitn == 5'h0F) begin
							cfg_word_out  <= {shreg[14:0], rom_din_in};
							cfg_valid_out <= 1'b1;
							state         <= ST_GAP;
						end
						bitn <= bitn + 5'h01;
					end
					rom_sclk_out <= ~rom_sclk_out;
				end
				default: begin
					rom_sclk_out   <= 1'b0;
					rom_select_out <= 1'b0;
					bitn           <= 5'h00;
					if (cfg_index_out == `PBS_ROM_WORDS - 8'h01) begin
						state    <= ST_DONE;
						done_out <= 1'b1;
					end else begin
						cfg_index_out <= cfg_index_out + 8'h01;
						state         <= ST_CMD;
					end
				end
				endcase
			end
		end
	end
endmodule // pbs_rom_loader

// file: pbs_port.v
// Packet buffer SRAM port with shared serial ROM autoload pins.
// Assumes an async SRAM meeting timing in PBS_ACC_CYC clocks and
// synchronous requesters that hold their request until granted.
//
// Behaviour
// - Drive buffer address bits 19..3; bits 19..16 only outside transceiver mode
// - Transceiver mode: top four pins become receive data
// - After reset, address pin 2 samples ROM
// - During autoload, pin 1 shifts data out
// - During autoload, pin 0 clocks the ROM
// - After autoload, low pins carry address again
// - Word mode: address bit 0 is don't-care
// - Sixteen bit two-way data bus
// - Output enable low only during reads
// - Chip select low during each access
// - Byte write enables: 1 high, 0 low
// - Drive dedicated ROM chip select output
// - Size select: 1 small ROM, 0 large
`include "pbs_map.vh"
module pbs_port #(
	parameter AW = 20,
	parameter DW = 16,
	// Serial ROM half period in clocks
	parameter ROM_HALF_CYC = (`PBS_ROM_HALF_NS + `PBS_CLK_NS - 1) / `PBS_CLK_NS
) (
	// Clock and reset
	input  wire            ref_clk_in,
	input  wire            reset_n_in,
	// Mode straps
	input  wire            xcvr_ext_in,
	input  wire            word_mode_in,
	input  wire            rom_size_sel_in,
	// Requests: index 0 host, 1 transmit DMA, 2 receive DMA
	input  wire [2:0]      req_in,
	input  wire [3*AW-1:0] req_addr_in,
	input  wire [2:0]      req_write_in,
	input  wire [3*DW-1:0] req_wdata_in,
	input  wire [5:0]      req_bytes_in,
	output reg  [2:0]      grant_out,
	output reg  [2:0]      done_out,
	output reg  [DW-1:0]   rdata_out,
	// Loaded configuration
	output reg  [15:0]     cfg_word_out,
	output reg  [7:0]      cfg_index_out,
	output reg             cfg_valid_out,
	output reg             load_done_out,
	// Receive data from high address pins in transceiver mode
	output reg  [3:0]      ext_rxd_out,
	// SRAM address pins
	output reg  [AW-1:3]   buf_addr_hi_out,
	output reg  [3:0]      buf_addr_hi_oe_out,
	input  wire [3:0]      buf_addr_hi_in,
	output reg             buf_addr2_or_rom_din_out,
	output reg             buf_addr2_or_rom_din_oe_out,
	input  wire            buf_addr2_or_rom_din_in,
	output reg             buf_addr1_or_rom_dout_out,
	output reg             buf_addr0_or_rom_sclk_out,
	// SRAM data and strobes
	output reg  [DW-1:0]   buf_data_out,
	output reg             buf_data_oe_out,
	input  wire [DW-1:0]   buf_data_in,
	output reg             buf_read_strobe_n_out,
	output reg             buf_select_n_out,
	output reg  [1:0]      buf_byte_write_n_out,
	// Serial ROM select
	output reg             rom_select_out
);
	localparam ST_IDLE = 2'h0;
	localparam ST_ACC  = 2'h1;
	localparam ST_END  = 2'h2;

	reg [1:0]    state;
	reg [2:0]    cnt;
	reg [1:0]    owner;
	reg          wr;
	reg [1:0]    pick;
	reg          any;
	wire         ld_sclk;
	wire         ld_dout;
	wire         ld_cs;
	wire [15:0]  ld_word;
	wire [7:0]   ld_idx;
	wire         ld_valid;
	wire         ld_done;
	wire [AW-1:0] pick_addr;

	// Field selects used by the launch logic
	function [AW-1:0] addr_of(input [3*AW-1:0] v, input [1:0] i);
		addr_of = v[i*AW +: AW];
	endfunction
	function [DW-1:0] data_of(input [3*DW-1:0] v, input [1:0] i);
		data_of = v[i*DW +: DW];
	endfunction

	pbs_rom_loader #(
		.HALF_CYC       (ROM_HALF_CYC)
	) u_loader (
		.ref_clk_in     (ref_clk_in),
		.reset_n_in     (reset_n_in),
		.size_small_in  (rom_size_sel_in),
		.rom_din_in     (buf_addr2_or_rom_din_in),
		.rom_sclk_out   (ld_sclk),
		.rom_dout_out   (ld_dout),
		.rom_select_out (ld_cs),
		.cfg_word_out   (ld_word),
		.cfg_index_out  (ld_idx),
		.cfg_valid_out  (ld_valid),
		.done_out       (ld_done)
	);

	// Address of the winning requester
	assign pick_addr = addr_of(req_addr_in, pick);

	always @* begin
		any  = |req_in;
		pick = 2'h0;
		if (req_in[`PBS_REQ_HOST])
			pick = 2'h0;
		else if (req_in[`PBS_REQ_RX])
			pick = 2'h2;
		else if (req_in[`PBS_REQ_TX])
			pick = 2'h1;
	end

	// Access sequencer and pin registers
	always @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state                       <= ST_IDLE;
			cnt                         <= 3'h0;
			owner                       <= 2'h0;
			wr                          <= 1'b0;
			grant_out                   <= 3'h0;
			done_out                    <= 3'h0;
			rdata_out                   <= {DW{1'b0}};
			cfg_word_out                <= 16'h0000;
			cfg_index_out               <= 8'h00;
			cfg_valid_out               <= 1'b0;
			load_done_out               <= 1'b0;
			ext_rxd_out                 <= 4'h0;
			buf_addr_hi_out             <= {(AW-3){1'b0}};
			buf_addr_hi_oe_out          <= 4'h0;
			buf_addr2_or_rom_din_out    <= 1'b0;
			buf_addr2_or_rom_din_oe_out <= 1'b0;
			buf_addr1_or_rom_dout_out   <= 1'b0;
			buf_addr0_or_rom_sclk_out   <= 1'b0;
			buf_data_out                <= {DW{1'b0}};
			buf_data_oe_out             <= 1'b0;
			buf_read_strobe_n_out       <= 1'b1;
			buf_select_n_out            <= 1'b1;
			buf_byte_write_n_out        <= 2'h3;
			rom_select_out              <= 1'b0;
		end else begin
			grant_out     <= 3'h0;
			done_out      <= 3'h0;
			cfg_word_out  <= ld_word;
			cfg_index_out <= ld_idx;
			cfg_valid_out <= ld_valid;
			load_done_out <= ld_done;
			rom_select_out <= ld_cs & ~ld_done;
			buf_addr_hi_oe_out <= xcvr_ext_in ? 4'h0 : 4'hF;
			ext_rxd_out <= xcvr_ext_in ?
				{buf_addr_hi_in[0], buf_addr_hi_in[1],
				 buf_addr_hi_in[2], buf_addr_hi_in[3]} : 4'h0;
			if (!ld_done) begin
				buf_addr2_or_rom_din_oe_out <= 1'b0;
				buf_addr1_or_rom_dout_out <= ld_dout;
				buf_addr0_or_rom_sclk_out <= ld_sclk;
			end else begin
				buf_addr2_or_rom_din_oe_out <= 1'b1;
			end
			case (state)
			ST_IDLE: begin
				if (any && load_done_out) begin
					owner     <= pick;
					wr        <= req_write_in[pick];
					grant_out <= 3'h1 << pick;
					cnt       <= `PBS_ACC_CYC;
					buf_addr_hi_out <= pick_addr[AW-1:3];
					buf_addr2_or_rom_din_out  <= pick_addr[2];
					buf_addr1_or_rom_dout_out <= pick_addr[1];
					buf_addr0_or_rom_sclk_out <= word_mode_in ? 1'b0 :
						pick_addr[0];
					buf_select_n_out <= 1'b0;
					buf_data_out    <= data_of(req_wdata_in, pick);
					buf_data_oe_out <= req_write_in[pick];
					buf_read_strobe_n_out <= req_write_in[pick];
					buf_byte_write_n_out <= req_write_in[pick] ?
						~req_bytes_in[pick*2 +: 2] : 2'h3;
					state <= ST_ACC;
				end
			end
			ST_ACC: begin
				cnt <= cnt - 3'h1;
				if (cnt == 3'h1) begin
					if (!wr)
						rdata_out <= buf_data_in;
					buf_read_strobe_n_out <= 1'b1;
					buf_byte_write_n_out  <= 2'h3;
					done_out              <= 3'h1 << owner;
					state                 <= ST_END;
				end
			end
			default: begin
				buf_select_n_out <= 1'b1;
				buf_data_oe_out  <= 1'b0;
				state            <= ST_IDLE;
			end
			endcase
		end
	end
endmodule // pbs_port

// file: pbs_port_monitor.sv
// Port checker for the packet buffer SRAM port.
// Assumes one clock domain with an active-low async reset.
module pbs_port_monitor (
	// Clock, reset and straps
	input wire       ref_clk_in, reset_n_in, xcvr_ext_in, word_mode_in,
	// Handshake and load state
	input wire [2:0] grant_out, done_out,
	input wire       load_done_out,
	// Pin enables and strobes
	input wire [3:0] buf_addr_hi_oe_out,
	input wire       buf_addr2_or_rom_din_oe_out, buf_addr0_or_rom_sclk_out,
	input wire       buf_data_oe_out, buf_read_strobe_n_out, buf_select_n_out,
	input wire [1:0] buf_byte_write_n_out
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);
	// Select held from grant cycle through done cycle
	sequence s_span;
		!buf_select_n_out [*4] ##1 buf_select_n_out;
	endsequence
	chk_read_strobe: assert property (
		!buf_read_strobe_n_out |-> !buf_select_n_out && &buf_byte_write_n_out)
		else $error("bad read strobe");
	chk_write_strobe: assert property (
		buf_byte_write_n_out != 2'h3 |-> !buf_select_n_out && buf_data_oe_out)
		else $error("bad write strobe");
	chk_load_first: assert property (
		!load_done_out |-> buf_select_n_out && grant_out == 3'h0)
		else $error("access during load");
	chk_grant_done: assert property (
		grant_out != 3'h0 |-> ##3 done_out == $past(grant_out, 3))
		else $error("done not three after grant");
	chk_select_span: assert property (grant_out != 3'h0 |-> s_span)
		else $error("bad select span");
	chk_rom_input: assert property (
		!load_done_out |-> !buf_addr2_or_rom_din_oe_out)
		else $error("pin two driven during load");
	chk_xcvr_dir: assert property (
		load_done_out && $stable(xcvr_ext_in)
		|-> buf_addr_hi_oe_out == {4{!xcvr_ext_in}})
		else $error("bad high pin direction");
	chk_word_addr: assert property (
		word_mode_in && !buf_select_n_out |-> !buf_addr0_or_rom_sclk_out)
		else $error("bit zero set in word mode");
endmodule // pbs_port_monitor
bind pbs_port pbs_port_monitor pbs_port_monitor_i (.*);

// file: pbs_far_model.sv
// Far side model: async packet SRAM and serial config ROM.
// Assumes the bench resolves the shared pins around it.
module pbs_far_model (
	// SRAM pins
	input  wire        sel_n, rd_n,
	input  wire [1:0]  wr_n,
	input  wire [19:0] addr,
	input  wire [15:0] dq_in,
	input  wire        dq_oe,
	output wire [15:0] dq_out,
	// ROM pins
	input  wire        cs, sclk, di,
	output wire        dout
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:255] = '{default: 16'h0000};
	logic [4:0]  cnt;
	logic [8:0]  cmd;
	logic        bit_q;
	// ROM word echoes its address only for the read opcode
	wire  [15:0] word = (cmd[8:6] == 3'h6) ? {8'h5A, 2'h0, cmd[5:0]} : 16'hFFFF;
	// word array; pull-down when nobody drives
	assign dq_out = dq_oe ? dq_in
		: (!sel_n && !rd_n) ? mem[addr[8:1]] : 16'h0000;
	// each byte lane latches as its strobe ends
	always @(posedge wr_n[1]) if (!sel_n) mem[addr[8:1]][15:8] <= dq_in[15:8];
	always @(posedge wr_n[0]) if (!sel_n) mem[addr[8:1]][7:0] <= dq_in[7:0];
	// command bits taken on rising clock while selected
	always @(posedge sclk or negedge cs) begin
		cnt <= cs ? cnt + 5'h01 : 5'h00;
		if (cs && cnt < 5'h09) cmd <= {cmd[7:0], di};
	end
	// data bit moves after falling clock; released line inverts
	always @(negedge sclk) if (cnt >= 5'h09) bit_q <= word[5'h18 - cnt];
	assign dout = cs ? bit_q : ~bit_q;
endmodule // pbs_far_model

// file: pbs_port_tb.sv
// Bench for the packet buffer SRAM port: ROM load, access, arbitration.
// Assumes the far side model and the port checker are compiled first.
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module pbs_port_tb;
	timeunit 1ns;
	timeprecision 1ps;
	int bad_count = 0;
	int comparisons = 0;
	// Port inputs; an early host read waits for the load
	logic        ref_clk_in = 1'h0, reset_n_in = 1'h0, xcvr_ext_in = 1'h0;
	logic        word_mode_in = 1'h1, rom_size_sel_in = 1'h1;
	logic [2:0]  req_in = 3'h1, req_write_in = 3'h0;
	logic [59:0] req_addr_in = 60'h0;
	logic [47:0] req_wdata_in = 48'h0;
	logic [5:0]  req_bytes_in = 6'h0;
	logic [3:0]  rxd_drive = 4'h0;
	// Port outputs and resolved pins
	wire [2:0]  grant_out, done_out;
	wire [15:0] rdata_out, cfg_word_out, buf_data_out, buf_data_in;
	wire [7:0]  cfg_index_out;
	wire [3:0]  ext_rxd_out, buf_addr_hi_oe_out, buf_addr_hi_in;
	wire [19:3] buf_addr_hi_out;
	wire [1:0]  buf_byte_write_n_out;
	wire cfg_valid_out, load_done_out, buf_addr2_or_rom_din_out, rom_line;
	wire buf_addr2_or_rom_din_oe_out, buf_addr2_or_rom_din_in;
	wire buf_addr1_or_rom_dout_out, buf_addr0_or_rom_sclk_out, rom_select_out;
	wire buf_data_oe_out, buf_read_strobe_n_out, buf_select_n_out;
	// Shared pins: whoever holds the enable drives
	assign buf_addr_hi_in = (buf_addr_hi_oe_out & buf_addr_hi_out[19:16])
		| (~buf_addr_hi_oe_out & rxd_drive);
	assign buf_addr2_or_rom_din_in = buf_addr2_or_rom_din_oe_out
		? buf_addr2_or_rom_din_out : rom_line;
	// Short ROM half period keeps the load within the cycle budget
	pbs_port #(.ROM_HALF_CYC(2)) pbs_port_i (.*);
	pbs_far_model pbs_far_model_i (.sel_n(buf_select_n_out),
		.rd_n(buf_read_strobe_n_out), .wr_n(buf_byte_write_n_out),
		.addr({buf_addr_hi_out, buf_addr2_or_rom_din_in,
		buf_addr1_or_rom_dout_out, buf_addr0_or_rom_sclk_out}),
		.dq_in(buf_data_out), .dq_oe(buf_data_oe_out), .dq_out(buf_data_in),
		.cs(rom_select_out), .sclk(buf_addr0_or_rom_sclk_out),
		.di(buf_addr1_or_rom_dout_out), .dout(rom_line));
	// Clock, 8 ns period
	initial forever #4 ref_clk_in = ~ref_clk_in;
	// One access on slot k, held until its done pulse
	task automatic access(input int k, input logic w, input logic [19:0] a,
		input logic [15:0] d, input logic [1:0] be, output logic [15:0] q);
		int n;
		@(posedge ref_clk_in);
		req_addr_in[k*20 +: 20] <= a;
		req_wdata_in[k*16 +: 16] <= d;
		req_bytes_in[k*2 +: 2] <= be;
		req_write_in[k] <= w;
		req_in[k] <= 1'h1;
		n = 0;
		do begin @(negedge ref_clk_in); n++; end
		while (done_out[k] !== 1'h1 && n < 20);
		q = rdata_out;
		`CHK(done_out[k], 1'h1)
		@(posedge ref_clk_in);
		req_in[k] <= 1'h0;
	endtask
	// Autoload: sixteen words, then pins back to address duty
	task automatic t_load();
		int n;
		int words;
		words = 0;
		for (n = 0; n < 4000 && load_done_out !== 1'h1; n++) begin
			@(negedge ref_clk_in);
			if (cfg_valid_out === 1'h1) begin
				words++;
				`CHK(cfg_word_out, {8'h5A, cfg_index_out})
			end
		end
		`CHK(words, 16)
		`CHK(rom_select_out, 1'h0)
		`CHK(buf_addr2_or_rom_din_oe_out, 1'h1)
		repeat (12) @(posedge ref_clk_in);
		req_in <= 3'h0;
		repeat (6) @(posedge ref_clk_in);
		$display("test load finished");
	endtask
	// Byte lane writes merge; pins 1 and 2 select words
	task automatic t_rw();
		logic [15:0] q;
		access(0, 1'h1, 20'h00012, 16'h1234, 2'h3, q);
		access(1, 1'h1, 20'h00012, 16'hABCD, 2'h2, q);
		access(2, 1'h1, 20'h00014, 16'h5678, 2'h1, q);
		access(2, 1'h0, 20'h00013, 16'h0000, 2'h0, q);
		`CHK(q, 16'hAB34)
		access(1, 1'h0, 20'h00014, 16'h0000, 2'h0, q);
		`CHK(q, 16'h0078)
		$display("test read write finished");
	endtask
	// Three requests at once: host, then receive, then transmit
	task automatic t_arb();
		logic [2:0] seen [$];
		logic [2:0] d;
		int n;
		@(posedge ref_clk_in);
		req_write_in <= 3'h0;
		req_in <= 3'h7;
		for (n = 0; n < 20; n++) begin
			@(negedge ref_clk_in);
			d = done_out;
			if (grant_out != 3'h0) seen.push_back(grant_out);
			@(posedge ref_clk_in);
			req_in <= req_in & ~d;
		end
		`CHK(seen.size(), 3)
		`CHK({seen[0], seen[1], seen[2]}, 9'h062)
		$display("test arbitration finished");
	endtask
	// Transceiver mode: pin 16 lands on bit 3, pin 17 on bit 2
	task automatic t_xcvr();
		@(posedge ref_clk_in);
		xcvr_ext_in <= 1'h1;
		rxd_drive <= 4'h3;
		repeat (3) @(negedge ref_clk_in);
		`CHK(buf_addr_hi_oe_out, 4'h0)
		`CHK(ext_rxd_out, 4'hC)
		@(posedge ref_clk_in);
		xcvr_ext_in <= 1'h0;
		repeat (3) @(negedge ref_clk_in);
		`CHK(buf_addr_hi_oe_out, 4'hF)
		$display("test transceiver finished");
	endtask
	// Verdict and end of run
	task automatic close_out();
		$display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Main sequence, reset held three cycles
	initial begin
		repeat (3) @(posedge ref_clk_in);
		reset_n_in <= 1'h1;
		t_load();
		t_rw();
		t_arb();
		t_xcvr();
		close_out();
	end
	// Watchdog past the expected load and access time
	initial begin
		#40000;
		bad_count++;
		close_out();
	end
endmodule // pbs_port_tb
